// >>> rtl/hpm_defines.svh
// Offsets, field positions, reset values and depths of the host port datapath map
`ifndef HPM_DEFINES_SVH
`define HPM_DEFINES_SVH
// Core-side register byte offsets
`define HPM_OFF_CTRL 8'h00
`define HPM_OFF_STAT 8'h04
`define HPM_OFF_TXD 8'h08
`define HPM_OFF_RXD 8'h0c
`define HPM_OFF_GDIR 8'h10
`define HPM_OFF_GDAT 8'h14
`define HPM_OFF_CIDX 8'h18
`define HPM_OFF_CDAT 8'h1c
`define HPM_OFF_HCMD 8'h20
`define HPM_OFF_SEMA 8'h24
`define HPM_OFF_DMAC 8'h28
// Fields of core_host_control_reg
`define HPM_CTL_MODE 2:0
`define HPM_CTL_TXAL 4:3
`define HPM_CTL_RXAL 6:5
`define HPM_CTL_FULL 7
`define HPM_CTL_HOST_ADDRESS_ENABLE 8
`define HPM_CTL_POL 9
`define HPM_CTL_INTA 10
`define HPM_CTL_HDMA 11
`define HPM_CTL_RST 24'h000000
// Alignment codes
`define HPM_AL_LEFT 2'h0
`define HPM_AL_RZERO 2'h1
`define HPM_AL_RSIGN 2'h2
// FIFO geometry and per-mode depth limits
`define HPM_FIFO_W 32
`define HPM_FIFO_D 8
`define HPM_DEPTH_PCI 4'h8
`define HPM_DEPTH_UB 4'h6
// Host memory window word indices
`define HPM_HW_CTRL 14'h0000
`define HPM_HW_STAT 14'h0001
`define HPM_HW_HCMD 14'h0002
`define HPM_HW_FIFO 14'h0007
// Universal-bus locations
`define HPM_UB_CTRL 3'h0
`define HPM_UB_STAT 3'h1
`define HPM_UB_HCMD 3'h2
`define HPM_UB_FIFO 3'h3
// Configuration space indices
`define HPM_CFG_CMD 6'h01
`define HPM_CFG_LAT 6'h03
`define HPM_CFG_BAR 6'h04
`endif

// >>> rtl/hpm_pkg.sv
// Types shared by the host port datapath map
package hpm_pkg;
  typedef logic [23:0] hpm_word_type;
  typedef logic [31:0] hpm_dword_type;
  typedef enum logic [2:0] {
    HPM_MODE_RESET = 3'h0,
    HPM_MODE_PCI = 3'h1,
    HPM_MODE_UB = 3'h2,
    HPM_MODE_GPIO = 3'h4
  } hpm_mode_type;
  typedef enum logic [1:0] {
    HPM_HS_IDLE = 2'h0,
    HPM_HS_FETCH = 2'h1,
    HPM_HS_ACK = 2'h3
  } hpm_hstate_type;
  typedef enum logic [2:0] {
    HPM_K_NONE, HPM_K_CTRL, HPM_K_STAT, HPM_K_HCMD,
    HPM_K_RSVD, HPM_K_FIFO, HPM_K_CFG, HPM_K_RETRY
  } hpm_kind_type;
endpackage : hpm_pkg

// >>> rtl/hpm_sync.sv
// Two-flop synchroniser for the host pins
module hpm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : hpm_sync

// >>> rtl/hpm_fifo.sv
// Data path FIFO memory with registered read data and a runtime depth limit
`include "hpm_defines.svh"
module hpm_fifo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [3:0] limit,
  input wire logic push,
  input wire hpm_pkg::hpm_dword_type wdata,
  input wire logic pop,
  output hpm_pkg::hpm_dword_type rdata,
  output logic full,
  output logic empty
);
  import hpm_pkg::*;
  hpm_dword_type mem_q [`HPM_FIFO_D];
  logic [2:0] wp_q, wp_d, rp_q, rp_d;
  logic [3:0] cnt_q, cnt_d;
  logic do_push, do_pop;
  assign full = (cnt_q >= limit);
  assign empty = (cnt_q == 4'h0);
  assign do_push = push & ~full & ~flush;
  assign do_pop = pop & ~empty & ~flush;
  always_comb begin
    wp_d = wp_q + {2'h0, do_push};
    rp_d = rp_q + {2'h0, do_pop};
    cnt_d = cnt_q + {3'h0, do_push} - {3'h0, do_pop};
    if (flush) begin
      wp_d = 3'h0;
      rp_d = 3'h0;
      cnt_d = 4'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
      rdata <= 32'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      if (do_pop) begin
        rdata <= mem_q[rp_q];
      end
    end
  end
  // Storage is not reset; the pointers guard it
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q] <= wdata;
    end
  end
endmodule : hpm_fifo

// >>> rtl/hpm_host_port.sv
// Host port front end: core-side AHB-Lite bank, host-side bank, FIFO paths, GPIO
`include "hpm_defines.svh"
module hpm_host_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire hpm_pkg::hpm_dword_type haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire hpm_pkg::hpm_dword_type hwdata,
  output hpm_pkg::hpm_dword_type hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic host_clk,
  input wire logic host_sel_n,
  input wire logic host_wr,
  input wire logic host_cfg_sel,
  input wire logic host_address_enable,
  input wire logic host_dma_ack,
  input wire logic [3:0] host_byte_enables,
  input wire hpm_pkg::hpm_dword_type host_addr,
  input wire hpm_pkg::hpm_dword_type host_data_in,
  output hpm_pkg::hpm_dword_type host_data_out,
  output logic host_data_oe_n,
  output logic host_data_request,
  output logic host_interrupt_a,
  output logic host_transfer_ack,
  output logic host_retry,
  output logic host_dma_request,
  input wire hpm_pkg::hpm_word_type gpio_in,
  output hpm_pkg::hpm_word_type gpio_out,
  output hpm_pkg::hpm_word_type gpio_oe_n,
  output logic core_rx_req,
  output logic core_tx_req,
  output logic [3:0] core_dma_req
);
  import hpm_pkg::*;

  function automatic hpm_dword_type be_mask(input logic [3:0] be);
    hpm_dword_type m;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

  function automatic hpm_dword_type out_align(input logic ub, input logic [1:0] al,
                                              input hpm_word_type w);
    hpm_dword_type r;
    if (ub) begin
      r = al[0] ? {16'h0, w[15:0]} : {16'h0, w[23:8]};
    end else begin
      case (al)
        `HPM_AL_RZERO: r = {8'h0, w};
        `HPM_AL_RSIGN: r = {{8{w[23]}}, w};
        default: r = {w, 8'h0};
      endcase
    end
    return r;
  endfunction : out_align

  function automatic hpm_word_type in_align(input logic ub, input logic [1:0] al,
                                            input hpm_dword_type d);
    hpm_word_type r;
    if (ub) begin
      case (al)
        `HPM_AL_RZERO: r = {8'h0, d[15:0]};
        `HPM_AL_RSIGN: r = {{8{d[15]}}, d[15:0]};
        default: r = {d[15:0], 8'h0};
      endcase
    end else begin
      r = al[0] ? d[23:0] : d[31:8];
    end
    return r;
  endfunction : in_align

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and host clock edge
  logic hclk_s, sel_s, wr_s, cfg_s, host_address_enable_s, dack_s, hclk_p_q;
  logic [3:0] be_s;
  hpm_dword_type addr_s, din_s;
  hpm_word_type gpio_s;
  hpm_sync #(.W(98), .INIT({2'b01, 96'h0})) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({host_clk, host_sel_n, host_wr, host_cfg_sel, host_address_enable, host_dma_ack,
        host_byte_enables, host_addr, host_data_in, gpio_in}),
    .q({hclk_s, sel_s, wr_s, cfg_s, host_address_enable_s, dack_s, be_s, addr_s, din_s, gpio_s})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core-side bank state
  hpm_word_type ctrl_q, ctrl_d, gdir_q, gdir_d, gdat_q, gdat_d;
  logic [1:0] cidx_q, cidx_d;
  logic [5:0] dmac_q, dmac_d;
  logic [15:0] tx_lo_q, tx_lo_d;
  logic tx_half_q, tx_half_d, rx_hi_q, rx_hi_d, rd_hi_q, rd_hi_d;
  logic a_wr_q, a_wr_d, rd_pend_q, rd_pend_d;
  logic [7:0] a_off_q, a_off_d;
  hpm_dword_type hrdata_d;
  logic hreadyout_d, take, cfg_we, hcmd_rd;
  // Host-side bank state
  hpm_hstate_type hs_q, hs_d;
  hpm_kind_type kind;
  logic tr_rd_q, tr_rd_d, tr_rty_q, tr_rty_d;
  logic [3:0] sem_q, sem_d;
  hpm_word_type hcmd_q, hcmd_d;
  logic hcv_q, hcv_d;
  logic [15:0] cmd_q, cmd_d, bar_q, bar_d;
  logic [7:0] lat_q, lat_d;
  hpm_dword_type dout_d, cfg_rd, ub_m, mrg;
  logic oe_n_d, ack_d, rty_d, dreq_d, inta_d, dmrq_d;
  // Shared FIFO handshakes
  logic rx_push, rx_pop, tx_push, tx_pop;
  logic rx_full, rx_empty, tx_full, tx_empty;
  hpm_dword_type rx_wd, tx_wd, rx_rd, tx_rd;
  hpm_mode_type mode;
  logic is_ub, flush, rise, pol;
  logic [3:0] limit;

  assign mode = hpm_mode_type'(ctrl_q[`HPM_CTL_MODE]);
  assign is_ub = (mode == HPM_MODE_UB);
  assign pol = ctrl_q[`HPM_CTL_POL];
  assign rise = hclk_s & ~hclk_p_q;
  assign flush = (mode == HPM_MODE_RESET);
  assign limit = is_ub ? `HPM_DEPTH_UB : `HPM_DEPTH_PCI;
  assign ub_m = is_ub ? 32'h00ffffff : 32'hffffffff;

  hpm_fifo u_rx (
    .clk(hclk), .rst_n(hresetn), .flush(flush), .limit(limit),
    .push(rx_push), .wdata(rx_wd), .pop(rx_pop), .rdata(rx_rd),
    .full(rx_full), .empty(rx_empty)
  );
  hpm_fifo u_tx (
    .clk(hclk), .rst_n(hresetn), .flush(flush), .limit(limit),
    .push(tx_push), .wdata(tx_wd), .pop(tx_pop), .rdata(tx_rd),
    .full(tx_full), .empty(tx_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Host address decode
  always_comb begin
    kind = HPM_K_NONE;
    case (mode)
      HPM_MODE_RESET: begin
        if (cfg_s) begin
          kind = HPM_K_CFG;
        end else begin
          kind = HPM_K_RETRY;
        end
      end
      HPM_MODE_PCI: begin
        if (dack_s) begin
          kind = HPM_K_FIFO;
        end else if (cfg_s) begin
          kind = HPM_K_CFG;
        end else if (addr_s[31:16] == bar_q) begin
          case (addr_s[15:2])
            `HPM_HW_CTRL: kind = HPM_K_CTRL;
            `HPM_HW_STAT: kind = HPM_K_STAT;
            `HPM_HW_HCMD: kind = HPM_K_HCMD;
            default: kind = (addr_s[15:2] < `HPM_HW_FIFO) ? HPM_K_RSVD : HPM_K_FIFO;
          endcase
        end
      end
      HPM_MODE_UB: begin
        if (dack_s) begin
          kind = HPM_K_FIFO;
        end else if (addr_s[10:3] == 8'h0 && (~ctrl_q[`HPM_CTL_HOST_ADDRESS_ENABLE] | host_address_enable_s)) begin
          case (addr_s[2:0])
            `HPM_UB_CTRL: kind = HPM_K_CTRL;
            `HPM_UB_STAT: kind = HPM_K_STAT;
            `HPM_UB_HCMD: kind = HPM_K_HCMD;
            `HPM_UB_FIFO: kind = HPM_K_FIFO;
            default: kind = HPM_K_RSVD;
          endcase
        end
      end
      default: kind = HPM_K_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host-side bank and transaction sequencer
  always_comb begin
    case (addr_s[7:2])
      `HPM_CFG_CMD: cfg_rd = {16'h0, cmd_q};
      `HPM_CFG_LAT: cfg_rd = {16'h0, lat_q, 8'h0};
      `HPM_CFG_BAR: cfg_rd = {bar_q, 16'h0};
      default: cfg_rd = 32'h0;
    endcase
    mrg = (cfg_rd & ~be_mask(be_s)) | (din_s & be_mask(be_s));
  end

  always_comb begin
    hs_d = hs_q;
    tr_rd_d = tr_rd_q;
    tr_rty_d = tr_rty_q;
    dout_d = host_data_out;
    sem_d = sem_q;
    hcmd_d = hcmd_q;
    hcv_d = hcv_q & ~hcmd_rd;
    cmd_d = cmd_q;
    lat_d = lat_q;
    bar_d = bar_q;
    rx_push = 1'b0;
    rx_wd = din_s & be_mask(be_s) & ub_m;
    tx_pop = 1'b0;
    if (cfg_we) begin
      case (cidx_q)
        2'h0: cmd_d = hwdata[15:0];
        2'h1: lat_d = hwdata[7:0];
        default: bar_d = hwdata[15:0];
      endcase
    end
    case (hs_q)
      HPM_HS_IDLE: begin
        if (rise && !sel_s && kind != HPM_K_NONE) begin
          tr_rd_d = ~wr_s;
          tr_rty_d = 1'b0;
          dout_d = 32'h0;
          hs_d = HPM_HS_ACK;
          case (kind)
            HPM_K_RETRY: tr_rty_d = 1'b1;
            HPM_K_CTRL: begin
              if (wr_s) begin
                sem_d = (sem_q & ~din_s[7:4]) | din_s[3:0];
              end else begin
                dout_d = {28'h0, sem_q};
              end
            end
            HPM_K_STAT: dout_d = {28'h0, hcv_q, rx_full, tx_empty, 1'b1};
            HPM_K_HCMD: begin
              if (wr_s) begin
                hcmd_d = din_s[23:0];
                hcv_d = 1'b1;
              end else begin
                dout_d = {8'h0, hcmd_q};
              end
            end
            HPM_K_FIFO: begin
              if (wr_s) begin
                tr_rty_d = rx_full;
                rx_push = ~rx_full;
              end else if (tx_empty) begin
                tr_rty_d = 1'b1;
              end else begin
                tx_pop = 1'b1;
                hs_d = HPM_HS_FETCH;
              end
            end
            HPM_K_CFG: begin
              if (!wr_s) begin
                dout_d = cfg_rd & be_mask(be_s);
              end else if (addr_s[7:2] == `HPM_CFG_CMD) begin
                cmd_d = mrg[15:0];
              end else if (addr_s[7:2] == `HPM_CFG_LAT) begin
                lat_d = mrg[15:8];
              end else if (addr_s[7:2] == `HPM_CFG_BAR) begin
                bar_d = mrg[31:16];
              end
            end
            default: dout_d = 32'h0;
          endcase
        end
      end
      HPM_HS_FETCH: begin
        dout_d = tx_rd & be_mask(be_s) & ub_m;
        hs_d = HPM_HS_ACK;
      end
      HPM_HS_ACK: begin
        if (sel_s) begin
          hs_d = HPM_HS_IDLE;
        end
      end
      default: hs_d = HPM_HS_IDLE;
    endcase
    if (flush && kind != HPM_K_CFG && hs_q != HPM_HS_ACK) begin
      hs_d = (hs_d == HPM_HS_FETCH) ? HPM_HS_IDLE : hs_d;
    end
    ack_d = ((hs_d == HPM_HS_ACK) & ~tr_rty_d) ^ pol;
    rty_d = ((hs_d == HPM_HS_ACK) & tr_rty_d) ^ pol;
    oe_n_d = ~((hs_d == HPM_HS_ACK) & tr_rd_d & ~tr_rty_d);
    dreq_d = (~flush & (~tx_empty | ~rx_full)) ^ pol;
    dmrq_d = (ctrl_q[`HPM_CTL_HDMA] & ~flush & (~tx_empty | ~rx_full)) ^ pol;
    inta_d = ctrl_q[`HPM_CTL_INTA] ^ pol;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_q <= HPM_HS_IDLE;
      hclk_p_q <= 1'b0;
      tr_rd_q <= 1'b0;
      tr_rty_q <= 1'b0;
      sem_q <= 4'h0;
      hcmd_q <= 24'h0;
      hcv_q <= 1'b0;
      cmd_q <= 16'h0;
      lat_q <= 8'h0;
      bar_q <= 16'h0;
      host_data_out <= 32'h0;
      host_data_oe_n <= 1'b1;
      host_transfer_ack <= 1'b0;
      host_retry <= 1'b0;
      host_data_request <= 1'b0;
      host_dma_request <= 1'b0;
      host_interrupt_a <= 1'b0;
    end else begin
      hs_q <= hs_d;
      hclk_p_q <= hclk_s;
      tr_rd_q <= tr_rd_d;
      tr_rty_q <= tr_rty_d;
      sem_q <= sem_d;
      hcmd_q <= hcmd_d;
      hcv_q <= hcv_d;
      cmd_q <= cmd_d;
      lat_q <= lat_d;
      bar_q <= bar_d;
      host_data_out <= dout_d;
      host_data_oe_n <= oe_n_d;
      host_transfer_ack <= ack_d;
      host_retry <= rty_d;
      host_data_request <= dreq_d;
      host_dma_request <= dmrq_d;
      host_interrupt_a <= inta_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core-side AHB-Lite slave; reads take one wait state for the FIFO fetch
  always_comb begin
    take = hsel & hready & htrans[1];
    a_wr_d = take & hwrite;
    rd_pend_d = take & ~hwrite;
    a_off_d = take ? haddr[7:0] : a_off_q;
    hreadyout_d = ~rd_pend_d;
    hrdata_d = hrdata;
    ctrl_d = ctrl_q;
    gdir_d = gdir_q;
    gdat_d = gdat_q;
    cidx_d = cidx_q;
    dmac_d = dmac_q;
    tx_lo_d = tx_lo_q;
    tx_half_d = tx_half_q;
    rx_hi_d = rx_hi_q;
    rd_hi_d = rd_hi_q;
    cfg_we = 1'b0;
    tx_push = 1'b0;
    tx_wd = out_align(is_ub, ctrl_q[`HPM_CTL_TXAL], hwdata[23:0]);
    rx_pop = 1'b0;
    hcmd_rd = 1'b0;
    if (a_wr_q) begin
      case (a_off_q)
        `HPM_OFF_CTRL: ctrl_d = hwdata[23:0];
        `HPM_OFF_GDIR: gdir_d = hwdata[23:0];
        `HPM_OFF_GDAT: gdat_d = hwdata[23:0];
        `HPM_OFF_CIDX: cidx_d = hwdata[1:0];
        `HPM_OFF_CDAT: cfg_we = 1'b1;
        `HPM_OFF_DMAC: dmac_d = hwdata[5:0];
        `HPM_OFF_TXD: begin
          // join two 16-bit words, first in low half
          if (ctrl_q[`HPM_CTL_FULL] && !is_ub) begin
            tx_half_d = ~tx_half_q;
            tx_lo_d = hwdata[15:0];
            tx_push = tx_half_q;
            tx_wd = {hwdata[15:0], tx_lo_q};
          end else begin
            tx_push = 1'b1;
          end
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (rd_pend_d && haddr[7:0] == `HPM_OFF_RXD) begin
      rd_hi_d = rx_hi_q;
      if (ctrl_q[`HPM_CTL_FULL] && !is_ub) begin
        rx_hi_d = rx_hi_q ? 1'b0 : ~rx_empty;
        rx_pop = ~rx_hi_q;
      end else begin
        rx_pop = 1'b1;
      end
    end
    if (rd_pend_d && haddr[7:0] == `HPM_OFF_HCMD) begin
      hcmd_rd = 1'b1;
    end
    if (rd_pend_q) begin
      case (a_off_q)
        `HPM_OFF_CTRL: hrdata_d = {8'h0, ctrl_q};
        `HPM_OFF_STAT: hrdata_d = {28'h0, hcv_q, ~tx_full, ~rx_empty, hs_q != HPM_HS_IDLE};
        `HPM_OFF_RXD: begin
          if (ctrl_q[`HPM_CTL_FULL] && !is_ub) begin
            hrdata_d = rd_hi_q ? {16'h0, rx_rd[31:16]} : {16'h0, rx_rd[15:0]};
          end else begin
            hrdata_d = {8'h0, in_align(is_ub, ctrl_q[`HPM_CTL_RXAL], rx_rd)};
          end
        end
        `HPM_OFF_GDIR: hrdata_d = {8'h0, gdir_q};
        `HPM_OFF_GDAT: hrdata_d = {8'h0, (gdat_q & gdir_q) | (gpio_s & ~gdir_q)};
        `HPM_OFF_CIDX: hrdata_d = {30'h0, cidx_q};
        `HPM_OFF_CDAT: hrdata_d = (cidx_q == 2'h0) ? {16'h0, cmd_q} :
                                  (cidx_q == 2'h1) ? {24'h0, lat_q} : {16'h0, bar_q};
        `HPM_OFF_HCMD: hrdata_d = {8'h0, hcmd_q};
        `HPM_OFF_SEMA: hrdata_d = {28'h0, sem_q};
        `HPM_OFF_DMAC: hrdata_d = {26'h0, dmac_q};
        default: hrdata_d = 32'h0;
      endcase
    end
    if (flush) begin
      tx_half_d = 1'b0;
      rx_hi_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core handshakes and GPIO pins
  logic rxr_d, txr_d;
  logic [3:0] dma_d;
  hpm_word_type goe_n_d;
  always_comb begin
    rxr_d = ~rx_empty;
    txr_d = ~tx_full & ~flush;
    dma_d = 4'h0;
    if (dmac_q[4]) begin
      dma_d[dmac_q[1:0]] = rxr_d;
    end
    if (dmac_q[5]) begin
      dma_d[dmac_q[3:2]] = dma_d[dmac_q[3:2]] | txr_d;
    end
    // pins free for GPIO in universal-bus and GPIO modes only
    goe_n_d = (is_ub || mode == HPM_MODE_GPIO) ? ~gdir_q : 24'hffffff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `HPM_CTL_RST;
      gdir_q <= 24'h0;
      gdat_q <= 24'h0;
      cidx_q <= 2'h0;
      dmac_q <= 6'h0;
      tx_lo_q <= 16'h0;
      tx_half_q <= 1'b0;
      rx_hi_q <= 1'b0;
      rd_hi_q <= 1'b0;
      a_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      a_off_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      core_rx_req <= 1'b0;
      core_tx_req <= 1'b0;
      core_dma_req <= 4'h0;
      gpio_out <= 24'h0;
      gpio_oe_n <= 24'hffffff;
    end else begin
      ctrl_q <= ctrl_d;
      gdir_q <= gdir_d;
      gdat_q <= gdat_d;
      cidx_q <= cidx_d;
      dmac_q <= dmac_d;
      tx_lo_q <= tx_lo_d;
      tx_half_q <= tx_half_d;
      rx_hi_q <= rx_hi_d;
      rd_hi_q <= rd_hi_d;
      a_wr_q <= a_wr_d;
      rd_pend_q <= rd_pend_q ? 1'b0 : rd_pend_d;
      a_off_q <= a_off_d;
      hrdata <= hrdata_d;
      hreadyout <= hreadyout_d;
      hresp <= 1'b0;
      core_rx_req <= rxr_d;
      core_tx_req <= txr_d;
      core_dma_req <= dma_d;
      gpio_out <= gdat_q;
      gpio_oe_n <= goe_n_d;
    end
  end
endmodule : hpm_host_port

// >>> sim/hpm_host.sv
// Host bus agent standing on the far side of the host port
module hpm_host (
  input wire logic hclk,
  input wire logic ack,
  input wire logic rty,
  output logic host_clk,
  output logic sel_n,
  output logic wr,
  output logic cfg,
  output logic dak,
  output logic [3:0] be,
  output logic [31:0] addr,
  output logic [31:0] din
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 0;
  int ph = 0;
  initial {host_clk, sel_n, wr, cfg, dak, be, addr, din} = {2'b01, 39'h0, 32'h5a5a5a5a};
  // Link clock runs only inside a frame, eight hclk per period
  always @(posedge hclk) begin
    ph <= run ? (ph + 1) % 8 : 0;
    host_clk <= run && ph >= 3 && ph < 7;
  end
  task automatic xfer(input logic w, input logic [1:0] k, input logic [3:0] b,
                      input logic [31:0] a, input logic [31:0] d, output logic r);
    int i;
    wr <= w;
    {cfg, dak} <= k;
    // lane enables held with the address
    be <= b;
    addr <= a;
    // Released data shows the inverse, never the last value
    din <= w ? d : ~din;
    sel_n <= 0;
    run <= 1;
    // hold everything until ack or retry
    for (i = 0; i < 64 && !(ack || rty); i++) @(posedge hclk);
    r = rty;
    sel_n <= 1;
    run <= 0;
    din <= ~din;
    for (i = 0; i < 16 && (ack || rty); i++) @(posedge hclk);
  endtask : xfer
endmodule : hpm_host

// >>> sim/hpm_chk.sv
// Timing checker for the host port register bus and host handshake
module hpm_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire hpm_pkg::hpm_dword_type hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic host_sel_n,
  input wire logic host_transfer_ack,
  input wire logic host_retry,
  input wire logic host_data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go = hsel && hready && htrans[1] && !hwrite;
  wire wr_go = hsel && hready && htrans[1] && hwrite;
  wire hs_busy = host_transfer_ack || host_retry;
  a_resp_okay: assert property (!hresp)
    else $error("bad response");
  a_read_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_fast: assert property (wr_go |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_oe_ack: assert property (!host_data_oe_n |-> host_transfer_ack)
    else $error("data driven without ack");
  a_ack_retry: assert property (!(host_transfer_ack && host_retry))
    else $error("ack with retry");
  a_ack_hold: assert property (host_transfer_ack && !host_sel_n |=> host_transfer_ack)
    else $error("ack dropped early");
  a_ack_drop: assert property ($rose(host_sel_n) |-> ##[1:6] !hs_busy)
    else $error("ack not released");
  a_oe_idle: assert property (host_sel_n [*6] |-> host_data_oe_n && !hs_busy)
    else $error("idle bus driven");
  c_read: cover property (rd_go);
  c_retry: cover property ($rose(host_retry));
  c_host_rd: cover property (host_transfer_ack && !host_data_oe_n);
endmodule : hpm_chk
bind hpm_host_port hpm_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .host_sel_n(host_sel_n), .host_transfer_ack(host_transfer_ack), .host_retry(host_retry),
  .host_data_oe_n(host_data_oe_n));

// >>> sim/hpm_host_port_tb_top.sv
// Bench for the host port: AHB master, host agent, result queue
`include "hpm_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module hpm_host_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dp = 0, ack_q = 0, rty;
  logic hrdy, ack, rtyo, oe_n, rxr, txr, lclk, sel_n, hwr, cfg, dak, dreq, inta, dmrq;
  logic [1:0] htrans = 0;
  logic [3:0] be, dmaq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, hdo, msk = '1, w, d, bar, addr, din;
  logic [23:0] gpio_in = 0, gpio_out, gpio_oe_n;
  logic [31:0] exp_q[$];
  int n_fail = 0, num_checks = 0, cyc = 0;
  hpm_host_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(), .host_clk(lclk), .host_sel_n(sel_n),
    .host_wr(hwr), .host_cfg_sel(cfg), .host_address_enable(1'b1), .host_dma_ack(dak),
    .host_byte_enables(be), .host_addr(addr), .host_data_in(din), .host_data_out(hdo),
    .host_data_oe_n(oe_n), .host_data_request(dreq), .host_interrupt_a(inta),
    .host_transfer_ack(ack), .host_retry(rtyo), .host_dma_request(dmrq), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .core_rx_req(rxr), .core_tx_req(txr),
    .core_dma_req(dmaq));
  hpm_host hm (.hclk(hclk), .ack(ack), .rty(rtyo), .host_clk(lclk), .sel_n(sel_n),
    .wr(hwr), .cfg(cfg), .dak(dak), .be(be), .addr(addr), .din(din));
  always #12.5 hclk = ~hclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Cut a hang short well past the expected run of under a thousand cycles
  always @(posedge hclk) if (++cyc == 8000) begin
    n_fail++;
    end_sim();
  end
  task automatic chk_q(input logic [31:0] g, input logic [31:0] m);
    logic [31:0] e;
    e = exp_q.size() ? exp_q.pop_front() : ~g;
    `CHK(g & m, e & m)
  endtask : chk_q
  always @(posedge hclk) begin
    if (rd_dp && hrdy) chk_q(hrdata, '1);
    if (ack && !ack_q && !oe_n) chk_q(hdo, msk);
    ack_q <= ack;
  end
  task automatic ahb(input logic we, input logic [31:0] a, input logic [31:0] v);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= we;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    rd_dp <= !we;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd_dp <= 0;
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    ahb(1, a, v);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(0, a, 0);
  endtask : rd
  initial begin
    w = $urandom(4668);
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    gpio_in <= $urandom;
    repeat (4) @(posedge hclk);
    `CHK({dreq, inta, dmrq, dmaq}, 7'h0)
    rd(`HPM_OFF_CTRL, 0);
    rd(32'h3c, 0);
    hm.xfer(1, 2'h1, 4'hf, 32'h1c, w, rty);
    `CHK(rty, 1'b1)
    bar = {16'($urandom), 16'h0};
    wr(`HPM_OFF_CIDX, 2);
    wr(`HPM_OFF_CDAT, bar[31:16]);
    rd(`HPM_OFF_CDAT, bar[31:16]);
    exp_q.push_back(bar);
    hm.xfer(0, 2'h2, 4'hf, 32'h10, 0, rty);
    $display("test reset_cfg done");
    for (int al = 0; al < 3; al++) begin
      wr(`HPM_OFF_CTRL, 32'h801 | al << 3 | (al % 2) << 5);
      w = {8'h0, 1'b1, 23'($urandom)};
      wr(`HPM_OFF_TXD, w);
      exp_q.push_back(al == 0 ? w << 8 : al == 1 ? w : {8'hff, w[23:0]});
      hm.xfer(0, 2'h1, 4'hf, bar | 32'h1c, 0, rty);
      d = $urandom;
      hm.xfer(1, 2'h1, 4'hf, bar | 32'h1c, d, rty);
      rd(`HPM_OFF_RXD, al % 2 ? d[23:0] : d[31:8]);
    end
    hm.xfer(1, 2'h1, 4'h7, bar | 32'h1c, d, rty);
    rd(`HPM_OFF_RXD, {8'h0, d[23:8]});
    wr(`HPM_OFF_CTRL, 32'h881);
    wr(`HPM_OFF_TXD, w[15:0]);
    wr(`HPM_OFF_TXD, d[15:0]);
    exp_q.push_back({d[15:0], w[15:0]});
    hm.xfer(0, 2'h1, 4'hf, bar | 32'h1c, 0, rty);
    hm.xfer(1, 2'h1, 4'hf, bar | 32'h1c, d, rty);
    rd(`HPM_OFF_RXD, d[15:0]);
    rd(`HPM_OFF_RXD, d[31:16]);
    hm.xfer(1, 2'h0, 4'hf, bar, 32'h5, rty);
    rd(`HPM_OFF_SEMA, 32'h5);
    hm.xfer(1, 2'h0, 4'hf, bar | 32'h8, d, rty);
    exp_q.push_back(32'hb);
    hm.xfer(0, 2'h0, 4'hf, bar | 32'h4, 0, rty);
    rd(`HPM_OFF_HCMD, d[23:0]);
    hm.xfer(1, 2'h1, 4'hf, bar | 32'h1c, d, rty);
    `CHK(rxr, 1'b1)
    wr(`HPM_OFF_CTRL, 0);
    wr(`HPM_OFF_CTRL, 32'h801);
    repeat (3) @(posedge hclk);
    `CHK(rxr, 1'b0)
    $display("test pci done");
    msk = 32'hffff;
    for (int al = 0; al < 3; al++) begin
      wr(`HPM_OFF_CTRL, 32'h802 | al << 5 | (al % 2) << 3);
      w = {8'h0, 1'b1, 23'($urandom)};
      wr(`HPM_OFF_TXD, w);
      exp_q.push_back(al % 2 ? w[15:0] : w[23:8]);
      hm.xfer(0, 2'h1, 4'hf, 32'h3, 0, rty);
      d = {16'h0, 1'b1, 15'($urandom)};
      hm.xfer(1, 2'h1, 4'hf, 32'h3, d, rty);
      rd(`HPM_OFF_RXD, al == 0 ? d << 8 : al == 1 ? d : {8'hff, d[15:0]});
    end
    for (int i = 0; i < 6; i++) wr(`HPM_OFF_TXD, i << 8);
    repeat (2) @(posedge hclk);
    `CHK(txr, 1'b0)
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(i);
      hm.xfer(0, 2'h1, 4'hf, 32'h3, 0, rty);
    end
    $display("test ub done");
    wr(`HPM_OFF_DMAC, 32'h3e);
    wr(`HPM_OFF_CTRL, 32'hc01);
    repeat (2) @(posedge hclk);
    `CHK({dreq, inta, dmrq, dmaq}, 7'h78)
    w = $urandom;
    wr(`HPM_OFF_CTRL, 32'h4);
    wr(`HPM_OFF_GDIR, w[23:0]);
    wr(`HPM_OFF_GDAT, ~w[23:0]);
    repeat (2) @(posedge hclk);
    `CHK(gpio_oe_n, ~w[23:0])
    `CHK(gpio_out, ~w[23:0])
    $display("test gpio done");
    end_sim();
  end
endmodule : hpm_host_port_tb_top
